// file: verilog/mmtmr_pkg.sv
// Shared constants, register layout and types of the multimode 16-bit timer
package mmtmr_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 16; // Register data width
  localparam int unsigned ADDR_W = 3; // Register address width
  localparam int unsigned CTRL_W = 14; // Used bits of the control register
  localparam int unsigned PRESC_W = 7; // Prescaler counter width, divide up to 128

  // ----------------------------------------------------------------------
  // Register offsets (word addresses on the plain port)
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0; // Control: enable, mode, options
  localparam logic [2:0] ADDR_COUNT = 3'h1; // Count value, write sets start count
  localparam logic [2:0] ADDR_RELOAD = 3'h2; // Reload value
  localparam logic [2:0] ADDR_MATCH = 3'h3; // PWM match value
  localparam logic [2:0] ADDR_STATUS = 3'h4; // Read-only status

  // ----------------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------------
  localparam int unsigned STAT_CAUSE_BIT = 0; // Capture cause flag
  localparam int unsigned STAT_OUT_BIT = 1; // Timer output level
  localparam int unsigned STAT_RUN_BIT = 2; // Dual-input mode counting
  localparam int unsigned STAT_FIRST_BIT = 3; // Input that started the count

  // ----------------------------------------------------------------------
  // Mode codes and option encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_CONT = 4'h1; // Continuous
  localparam logic [3:0] MODE_COUNTER = 4'h2; // Input transition counter
  localparam logic [3:0] MODE_PWM = 4'h3; // Single-output PWM
  localparam logic [3:0] MODE_DUAL = 4'hA; // Dual-input triggered one-shot
  localparam logic [1:0] OUT_RELOAD_PULSE = 2'h0; // Pulse at reload
  localparam logic [1:0] OUT_HOLD = 2'h1; // Active from start to reload
  localparam logic [1:0] OUT_SAME_PULSE = 2'h2; // Pulse on same-input trigger
  localparam logic [1:0] OUT_OPP_PULSE = 2'h3; // Pulse on opposite-input trigger
  localparam logic [1:0] IRQ_ALL = 2'h0; // Reloads and triggers
  localparam logic [1:0] IRQ_SAME = 2'h1; // Same-input triggers only
  localparam logic [1:0] IRQ_OPP = 2'h2; // Opposite-input triggers only
  localparam logic [1:0] IRQ_RELOAD = 2'h3; // Reloads only

  // ----------------------------------------------------------------------
  // Reset and restart values
  // ----------------------------------------------------------------------
  localparam logic [15:0] COUNT_RESTART = 16'h0001; // Count after every reload
  localparam logic [15:0] COUNT_RST = 16'h0001; // Count after reset
  localparam logic [15:0] RELOAD_RST = 16'hFFFF; // Reload after reset
  localparam logic [15:0] MATCH_RST = 16'h0000; // Match after reset
  localparam logic [6:0] PRESC_RST = 7'h00; // Prescaler counter after reset

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Control register layout, bit 0 is the enable
  typedef struct packed {
    logic alt_out_en; // Drive the output pin alternate function
    logic [2:0] prescale; // Divide by two to the power of this
    logic [1:0] irq_cause_select; // Interrupt cause choice
    logic [1:0] output_behaviour_select; // Dual-input output choice
    logic polarity_select; // Edge and output level choice
    logic [3:0] operating_mode_select; // Mode code
    logic count_enable_bit; // Run or stop
  } mmtmr_ctrl_t;

  // Phase of the dual-input one-shot
  typedef enum logic {
    MMTMR_IDLE,
    MMTMR_COUNTING
  } mmtmr_phase_t;

  // Whole state of the timer core
  typedef struct packed {
    mmtmr_ctrl_t ctrl; // Control register
    logic [15:0] count; // Current count
    logic [15:0] reload; // Reload value
    logic [15:0] match; // PWM match value
    mmtmr_phase_t phase; // Dual-input phase
    logic first_src; // Zero when input 0 started the count
    logic capture_cause_flag; // Last interrupt came from a trigger
    logic out; // Timer output level
    logic pulse; // A one-clock output pulse is showing
    logic pin; // Pin copy of the output
    logic irq; // Interrupt request pulse
    logic [15:0] rdata; // Read data
  } mmtmr_state_t;

endpackage

// file: verilog/mmtmr_edge.sv
// Edge detector for one timer input with selectable direction
`timescale 1ns/1ps

module mmtmr_edge (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic sig_in,
  input wire logic falling_in,
  output logic edge_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic prev; // Input level one clock ago
  } mmtmr_edge_state_t;

  mmtmr_edge_state_t q; // Registered state
  mmtmr_edge_state_t d; // Next state

  // Next state and edge decode; the input is already synchronous
  always_comb begin
    d = q;
    d.prev = sig_in;
    if (falling_in) begin
      edge_out = q.prev & ~sig_in;
    end else begin
      edge_out = ~q.prev & sig_in;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

endmodule

// file: verilog/mmtmr_presc.sv
// Power-of-two prescaler giving one tick per divided timer clock
`timescale 1ns/1ps

module mmtmr_presc (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic [2:0] prescale_in,
  output logic tick_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] cnt; // Clocks since the last tick
  } mmtmr_presc_state_t;

  mmtmr_presc_state_t q; // Registered state
  mmtmr_presc_state_t d; // Next state
  logic [6:0] last; // Terminal count for the chosen division

  // Restarts whenever stopped so the first tick after a start is a full period
  always_comb begin
    d = q;
    last = 7'(({7'h00, 1'b1} << prescale_in) - 8'h01);
    tick_out = run_in && (q.cnt == last);
    if (!run_in || tick_out) begin
      d.cnt = mmtmr_pkg::PRESC_RST;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q.cnt <= mmtmr_pkg::PRESC_RST;
    end else if (ce_in) begin
      q <= d;
    end
  end

endmodule

// file: verilog/mmtmr_top.sv
// Multimode 16-bit timer: continuous, counter, PWM and dual-input one-shot
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module mmtmr_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic tin0_in,
  input wire logic tin1_in,
  output logic [15:0] rdata_out,
  output logic timer_out,
  output logic pin_out,
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  mmtmr_pkg::mmtmr_state_t q; // Registered state
  mmtmr_pkg::mmtmr_state_t d; // Next state
  logic edge0; // Trigger or count edge on input 0
  logic edge1; // Trigger edge on input 1
  logic presc_tick; // Divided timer clock
  logic presc_run; // Prescaler may run
  logic tick; // Count step for this clock
  logic hit; // Count step taken while the count equals the reload value
  logic same_trig; // Trigger from the input that started the count
  logic opp_trig; // Trigger from the other input
  logic trig_irq; // Trigger that the cause select lets through
  logic is_dual; // Dual-input mode selected
  logic ctrl_wr; // Write to the control register

  // ----------------------------------------------------------------------
  // Input edges
  // ----------------------------------------------------------------------
  // Input 0 edge direction follows the polarity select
  mmtmr_edge u_edge0 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .sig_in(tin0_in),
    .falling_in(q.ctrl.polarity_select),
    .edge_out(edge0)
  );

  // Input 1 shares the same edge direction
  mmtmr_edge u_edge1 (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .sig_in(tin1_in),
    .falling_in(q.ctrl.polarity_select),
    .edge_out(edge1)
  );

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // Dual mode only runs it while counting, so each pass starts a full period
  assign is_dual = q.ctrl.operating_mode_select == mmtmr_pkg::MODE_DUAL;
  assign presc_run = q.ctrl.count_enable_bit &&
                     (q.ctrl.operating_mode_select != mmtmr_pkg::MODE_COUNTER) &&
                     (!is_dual || q.phase == mmtmr_pkg::MMTMR_COUNTING);

  mmtmr_presc u_presc (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .run_in(presc_run),
    .prescale_in(q.ctrl.prescale),
    .tick_out(presc_tick)
  );

  // Counter mode steps on input edges; the bypass counts every selected edge,
  // even at one in two clocks, so no synchronous source loses counts
  assign tick = (q.ctrl.operating_mode_select == mmtmr_pkg::MODE_COUNTER) ?
                edge0 : presc_tick;
  assign hit = tick && (q.count == q.reload);
  assign ctrl_wr = wr_in && (addr_in == mmtmr_pkg::ADDR_CTRL);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Mode behaviour first, then software writes, which win over the count
  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.pulse = 1'b0;
    d.rdata = '0;
    same_trig = q.first_src ? edge1 : edge0;
    opp_trig = q.first_src ? edge0 : edge1;
    trig_irq = ((q.ctrl.irq_cause_select == mmtmr_pkg::IRQ_ALL) && (edge0 || edge1)) ||
               ((q.ctrl.irq_cause_select == mmtmr_pkg::IRQ_SAME) && same_trig) ||
               ((q.ctrl.irq_cause_select == mmtmr_pkg::IRQ_OPP) && opp_trig);
    // Nothing moves while stopped
    if (q.ctrl.count_enable_bit) begin
      unique case (q.ctrl.operating_mode_select)
        // Free-running modes share the reload and toggle behaviour
        mmtmr_pkg::MODE_CONT, mmtmr_pkg::MODE_COUNTER: begin
          if (hit) begin
            d.count = mmtmr_pkg::COUNT_RESTART;
            d.out = ~q.out;
            d.irq = 1'b1;
            d.capture_cause_flag = 1'b0;
          end else if (tick) begin
            d.count = q.count + 16'h0001;
          end
        end
        // PWM: idle level is the polarity, the match flips to its inverse
        mmtmr_pkg::MODE_PWM: begin
          if (hit) begin
            d.count = mmtmr_pkg::COUNT_RESTART;
            d.out = q.ctrl.polarity_select;
            d.irq = 1'b1;
            d.capture_cause_flag = 1'b0;
          end else if (tick) begin
            if (q.count == q.match) begin
              d.out = ~q.ctrl.polarity_select;
            end
            d.count = q.count + 16'h0001;
          end
        end
        // Dual-input one-shot
        mmtmr_pkg::MODE_DUAL: begin
          // A one-clock pulse returns to the idle level
          if (q.pulse) begin
            d.out = q.ctrl.polarity_select;
          end
          unique case (q.phase)
            // Input 0 wins when both arrive in the same clock
            mmtmr_pkg::MMTMR_IDLE: begin
              if (edge0 || edge1) begin
                d.phase = mmtmr_pkg::MMTMR_COUNTING;
                d.first_src = ~edge0;
                if (q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_HOLD) begin
                  d.out = ~q.ctrl.polarity_select;
                end
              end
            end
            // Count, watch for reload and for further triggers
            mmtmr_pkg::MMTMR_COUNTING: begin
              if (hit) begin
                d.count = mmtmr_pkg::COUNT_RESTART;
                d.phase = mmtmr_pkg::MMTMR_IDLE;
                if (q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_RELOAD_PULSE) begin
                  d.out = ~q.ctrl.polarity_select;
                  d.pulse = 1'b1;
                end else if (q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_HOLD) begin
                  d.out = q.ctrl.polarity_select;
                end
                if (q.ctrl.irq_cause_select == mmtmr_pkg::IRQ_ALL ||
                    q.ctrl.irq_cause_select == mmtmr_pkg::IRQ_RELOAD) begin
                  d.irq = 1'b1;
                  d.capture_cause_flag = 1'b0;
                end
              end else if (tick) begin
                d.count = q.count + 16'h0001;
              end
              if (((q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_SAME_PULSE) &&
                   same_trig) ||
                  ((q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_OPP_PULSE) &&
                   opp_trig)) begin
                d.out = ~q.ctrl.polarity_select;
                d.pulse = 1'b1;
              end
              // Placed after the reload so a trigger in the same clock wins
              if (trig_irq) begin
                d.irq = 1'b1;
                d.capture_cause_flag = 1'b1;
              end
            end
          endcase
        end
        // Unused mode codes leave everything as it is
        default: begin
        end
      endcase
    end
    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        // Starting the timer sets the initial output level and idles dual mode
        mmtmr_pkg::ADDR_CTRL: begin
          d.ctrl = mmtmr_pkg::mmtmr_ctrl_t'(wdata_in[13:0]);
          if (d.ctrl.count_enable_bit && !q.ctrl.count_enable_bit) begin
            d.out = d.ctrl.polarity_select;
            d.pulse = 1'b0;
            d.phase = mmtmr_pkg::MMTMR_IDLE;
          end
        end
        mmtmr_pkg::ADDR_COUNT: begin
          d.count = wdata_in;
        end
        mmtmr_pkg::ADDR_RELOAD: begin
          d.reload = wdata_in;
        end
        mmtmr_pkg::ADDR_MATCH: begin
          d.match = wdata_in;
        end
        default: begin
        end
      endcase
    end
    // Register reads, unmapped addresses return zero
    if (rd_in) begin
      unique case (addr_in)
        mmtmr_pkg::ADDR_CTRL: d.rdata = {2'b00, q.ctrl};
        mmtmr_pkg::ADDR_COUNT: d.rdata = q.count;
        mmtmr_pkg::ADDR_RELOAD: d.rdata = q.reload;
        mmtmr_pkg::ADDR_MATCH: d.rdata = q.match;
        mmtmr_pkg::ADDR_STATUS: begin
          d.rdata[mmtmr_pkg::STAT_CAUSE_BIT] = q.capture_cause_flag;
          d.rdata[mmtmr_pkg::STAT_OUT_BIT] = q.out;
          d.rdata[mmtmr_pkg::STAT_RUN_BIT] = q.phase == mmtmr_pkg::MMTMR_COUNTING;
          d.rdata[mmtmr_pkg::STAT_FIRST_BIT] = q.first_src;
        end
        default: d.rdata = '0;
      endcase
    end
    // Pin copy registered alongside so both outputs come from flops
    d.pin = d.ctrl.alt_out_en ? d.out : 1'b0;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Clock enable low freezes all state including the outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.count <= mmtmr_pkg::COUNT_RST;
      q.reload <= mmtmr_pkg::RELOAD_RST;
      q.match <= mmtmr_pkg::MATCH_RST;
      q.phase <= mmtmr_pkg::MMTMR_IDLE;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign rdata_out = q.rdata;
  assign timer_out = q.out;
  assign pin_out = q.pin;
  assign irq_out = q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_cont_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && !wr_in && hit &&
     q.ctrl.operating_mode_select == mmtmr_pkg::MODE_CONT)
    |=> (q.count == 16'h0001) && irq_out && (timer_out != $past(timer_out)))
    else $error("continuous reload did not restart, interrupt and toggle");

  a_disabled_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && !q.ctrl.count_enable_bit && !wr_in)
    |=> (q.count == $past(q.count)) && !irq_out && (timer_out == $past(timer_out)))
    else $error("stopped timer changed count, output or interrupt");

  a_dual_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && is_dual && !wr_in &&
     q.phase == mmtmr_pkg::MMTMR_IDLE && (edge0 || edge1))
    |=> (q.phase == mmtmr_pkg::MMTMR_COUNTING) && (q.first_src == !$past(edge0)))
    else $error("dual mode trigger did not start counting");

  a_dual_idle_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && is_dual && !wr_in && hit &&
     q.phase == mmtmr_pkg::MMTMR_COUNTING)
    |=> (q.phase == mmtmr_pkg::MMTMR_IDLE) && (q.count == 16'h0001))
    else $error("dual mode reload did not return to idle at 0001");

  a_reload_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.pulse && is_dual && q.ctrl.count_enable_bit && !wr_in &&
     q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_RELOAD_PULSE)
    |-> (timer_out != q.ctrl.polarity_select) ##1 (timer_out == q.ctrl.polarity_select))
    else $error("reload pulse not exactly one clock");

  a_cause_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && is_dual && !wr_in && trig_irq &&
     q.phase == mmtmr_pkg::MMTMR_COUNTING)
    |=> irq_out && q.capture_cause_flag)
    else $error("trigger interrupt did not set cause flag");

  a_counter_bypass: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && !wr_in && !edge0 &&
     q.ctrl.operating_mode_select == mmtmr_pkg::MODE_COUNTER)
    |=> (q.count == $past(q.count)))
    else $error("counter mode stepped without an input 0 edge");

  a_counter_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && !wr_in && hit &&
     q.ctrl.operating_mode_select == mmtmr_pkg::MODE_COUNTER)
    |=> (q.count == mmtmr_pkg::COUNT_RESTART) && irq_out && (timer_out != $past(timer_out)))
    else $error("counter reload did not restart, interrupt and toggle");

  a_pwm_match: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && !wr_in && tick && !hit &&
     q.ctrl.operating_mode_select == mmtmr_pkg::MODE_PWM && q.count == q.match)
    |=> (timer_out == !q.ctrl.polarity_select))
    else $error("PWM output wrong after match");

  a_pin_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ##1 (pin_out == (q.ctrl.alt_out_en & timer_out)))
    else $error("pin output does not follow timer output gating");

  a_pwm_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && !wr_in && hit &&
     q.ctrl.operating_mode_select == mmtmr_pkg::MODE_PWM)
    |=> (q.count == mmtmr_pkg::COUNT_RESTART) && irq_out &&
        (timer_out == q.ctrl.polarity_select))
    else $error("PWM reload did not restart, interrupt and restore level");

  a_trig_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && q.ctrl.count_enable_bit && is_dual && !wr_in &&
     q.phase == mmtmr_pkg::MMTMR_COUNTING &&
     ((q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_SAME_PULSE && same_trig) ||
      (q.ctrl.output_behaviour_select == mmtmr_pkg::OUT_OPP_PULSE && opp_trig)))
    |=> (timer_out != q.ctrl.polarity_select) ##1 (timer_out == q.ctrl.polarity_select))
    else $error("trigger output pulse not exactly one clock");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && is_dual && q.phase == mmtmr_pkg::MMTMR_IDLE) |=> !irq_out)
    else $error("dual mode interrupt raised while idle");

endmodule

// file: test/mmtmr_src.sv
// Model of the two timer input sources
`timescale 1ns/1ps

module mmtmr_src (
  input wire logic clk_in,
  input wire logic [1:0] want_in,
  output logic [1:0] tin_out
);
  // ----
  // Level hold
  // ----
  logic [1:0][1:0] hold_q = '0; // Clocks left before a line may move
  logic [1:0] lvl_q = 2'h0; // Levels now shown on the lines
  assign tin_out = lvl_q;
  // Each level stands four clocks, so edges on a line come at most one in four clocks
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (hold_q[i] != 2'h0) begin
        hold_q[i] <= hold_q[i] - 2'h1;
      end else if (want_in[i] != lvl_q[i]) begin
        lvl_q[i] <= want_in[i];
        hold_q[i] <= 2'h3;
      end
    end
  end
endmodule

// file: test/mmtmr_bench.sv
// Self-checking bench of the multimode 16-bit timer
`timescale 1ns/1ps

module mmtmr_bench;
  // ----
  // Signals
  // ----
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once per random-start continuous run
  logic [1:0] want = 2'h0; // Levels asked of the sources
  logic [1:0] tin;
  logic [15:0] rdata_out;
  logic timer_out;
  logic pin_out;
  logic irq_out;
  logic rd_d = 1'b0; // A read was taken at the last edge
  logic [15:0] expq[$]; // Expected read data, oldest first
  logic [31:0] seed = 32'h15;
  int n_errors = 0;
  int checks_done = 0;
  int n_irq = 0; // Interrupt pulse cycles seen
  int n_out = 0; // Cycles with the output high
  int cycles = 0;
  int wraps; // Reloads reached by the last count walk

  always #5 clk_in = ~clk_in;

  // Clock enable drops for three clocks in each random-start continuous run
  mmtmr_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .tin0_in(tin[0]), .tin1_in(tin[1]), .rdata_out(rdata_out),
    .timer_out(timer_out), .pin_out(pin_out), .irq_out(irq_out));
  mmtmr_src src (.clk_in(clk_in), .want_in(want), .tin_out(tin));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Count after k steps; a step at the reload value restarts from one
  function automatic logic [15:0] nxt(logic [15:0] c, logic [15:0] r, int k);
    wraps = 0;
    repeat (k) begin
      wraps += (c == r);
      c = (c == r) ? 16'h0001 : c + 16'h0001;
    end
    return c;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    expq.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // Raise then drop the chosen lines, slowly
  task automatic pulse(input logic [1:0] m);
    want <= want | m;
    repeat (5) @(posedge clk_in);
    want <= want & ~m;
    repeat (5) @(posedge clk_in);
  endtask

  // Output and pin high cycles over a whole number of periods
  task automatic duty(input logic [15:0] ctl, input logic [15:0] m, input logic [15:0] r,
      input logic [15:0] eh, input logic [15:0] ep);
    logic [15:0] hi;
    logic [15:0] pn;
    wr(3'h0, 16'h0000);
    wr(3'h3, m);
    wr(3'h2, r);
    wr(3'h1, 16'h0001);
    wr(3'h0, ctl);
    hi = 16'h0000;
    pn = 16'h0000;
    repeat (20) @(posedge clk_in);
    repeat (10 * int'(r)) begin
      @(posedge clk_in);
      hi = hi + timer_out;
      pn = pn + pin_out;
    end
    check(hi, eh);
    check(pn, ep);
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----
  // Watcher: read data, pulses, hang limit
  // ----
  always @(posedge clk_in) begin
    cycles++;
    n_irq += (irq_out === 1'b1);
    n_out += (timer_out === 1'b1);
    if (rd_d) begin
      check(rdata_out, expq.pop_front());
    end
    rd_d <= rd_in;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    logic [15:0] r;
    logic [15:0] m;
    logic [15:0] c;
    int i0;
    int o0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    wr(3'h4, 16'hFFFF); // Read-only status must ignore this
    wr(3'h6, 16'h1234); // Unmapped place
    for (int a = 0; a < 7; a++) begin
      rd(3'(a), (a == 1) ? 16'h0001 : (a == 2) ? 16'hFFFF : 16'h0000);
    end
    // Continuous mode from a random start count
    for (int t = 0; t < 4; t++) begin
      r = 16'h0002 + 16'(rnd() % 6);
      c = 16'h0001 + 16'(rnd() % r);
      i0 = int'(rnd() % 20);
      wr(3'h0, 16'h0000);
      wr(3'h1, c);
      wr(3'h2, r);
      wr(3'h0, 16'h0003);
      ce <= 1'b0; // Frozen clocks must not step the count
      repeat (3) @(posedge clk_in);
      ce <= 1'b1;
      repeat (i0) @(posedge clk_in);
      rd(3'h1, nxt(c, r, i0 + 1));
    end
    m = 16'h0001 + 16'(rnd() % (r - 16'h0001));
    duty(16'h2003, m, r, 16'(5 * r), 16'(5 * r));
    duty(16'h2027, m, r, 16'(10 * m), 16'(10 * m));
    duty(16'h0007, m, r, 16'(10 * (r - m)), 16'h0000);
    // Counter mode on falling edges, largest prescale set; input 1 must not count
    wr(3'h0, 16'h0000);
    wr(3'h1, 16'h0001);
    wr(3'h2, 16'h0003);
    wr(3'h0, 16'h1C25);
    i0 = n_irq;
    o0 = 4 + int'(rnd() % 6);
    c = nxt(16'h0001, 16'h0003, o0);
    repeat (o0) pulse(2'h3);
    wr(3'h0, 16'h1C24);
    pulse(2'h1);
    rd(3'h1, c);
    rd(3'h4, {14'h0000, ~wraps[0], 1'b0});
    check(16'(n_irq - i0), 16'(wraps));
    // Dual-input one-shot started by input 1, every interrupt and output choice
    for (int sel = 0; sel < 4; sel++) begin
      wr(3'h0, 16'h0000);
      repeat (10) @(posedge clk_in);
      wr(3'h1, 16'h0001);
      wr(3'h2, 16'h0028);
      wr(3'h0, 16'h0015 | (16'(sel) << 6) | (16'(sel) << 8));
      i0 = n_irq;
      o0 = n_out;
      pulse(2'h2); // Start, then opposite, then same trigger
      pulse(2'h1);
      pulse(2'h2);
      repeat (40) @(posedge clk_in);
      check(16'(n_irq - i0), (sel == 0) ? 16'h0003 : 16'h0001);
      check(16'(n_out - o0), (sel == 1) ? 16'h0028 : 16'h0001);
      rd(3'h4, 16'h0008 | 16'(sel == 1 || sel == 2));
      rd(3'h1, 16'h0001);
    end
    test_done();
  end
endmodule
